// ### common/afsc_pkg.sv
// Shared constants, types and helpers for the converter sequencer link
package afsc_pkg;
	// Serial frame
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] CMD_BITS = 5'h04;
	localparam logic [3:0] CMD_SLEEP = 4'h8;
	localparam logic [3:0] CMD_RD_CFG = 4'h9;
	localparam logic [3:0] CMD_WR_CFG = 4'hA;
	localparam logic [3:0] CMD_RD_FIFO = 4'hE;
	localparam logic [15:0] SLEEP_WORD = 16'h8000;
	localparam logic [15:0] INIT_WORD = 16'hA000;
	// Configuration field positions and reset value
	localparam int CFG_THR_LO = 0;
	localparam int CFG_SEQ_LO = 2;
	localparam int CFG_PIN_INT = 4;
	localparam int CFG_MODE_LO = 5;
	localparam int CFG_DIV2 = 7;
	localparam int CFG_EXT = 8;
	localparam logic [11:0] CFG_RESET = 12'h000;
	localparam logic [11:0] CODE_FULL = 12'hFFF;
	localparam logic [11:0] CODE_ZERO = 12'h000;
	// Result storage and conversion timing
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] CONV_CLOCKS = 4'hE;
	localparam logic [2:0] OVERHEAD_SCLKS = 3'h4;
	localparam int CLOCK_MHZ = 200;
	localparam int WAKE_MS = 20;
	localparam int WAKE_CYCLES = WAKE_MS * 1000 * CLOCK_MHZ;
	localparam int CONV_MAX_MHZ = 10;
	localparam int SCLK_HALF = CLOCK_MHZ / (2 * CONV_MAX_MHZ);
	// Host register map
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_RESULT = 4'h8;
	localparam logic [3:0] REG_CTRL = 4'hC;
	localparam int CTRL_START = 0;
	localparam int CTRL_SLEEP = 1;

	typedef enum logic [1:0] {MODE_ONE_SHOT, MODE_REPEAT, MODE_SWEEP, MODE_REPEAT_SWEEP} afsc_mode_t;

	// Entries needed to reach the fill threshold: full, 3/4, 1/2, 1/4
	function automatic logic [3:0] thr_count(input logic [1:0] code);
		unique case (code)
			2'h0: return 4'h8;
			2'h1: return 4'h6;
			2'h2: return 4'h4;
			2'h3: return 4'h2;
		endcase
	endfunction

	// Channel at a position of the programmed sweep sequence
	function automatic logic [2:0] sweep_ch(input logic [1:0] seq, input logic [2:0] idx);
		unique case (seq)
			2'h0: return idx;
			2'h1: return {idx[1:0], 1'b0};
			2'h2: return {1'b0, idx[2:1]};
			2'h3: return {1'b0, idx[1:0]};
		endcase
	endfunction

	// Scales a sample between the references, clamped at both ends
	function automatic logic [11:0] sat_code(input logic [15:0] s, input logic [15:0] u, input logic [15:0] l);
		logic [27:0] q;
		q = 28'h000_0000;
		if (s >= u)
			return CODE_FULL;
		if (s <= l)
			return CODE_ZERO;
		q = {12'h000, 16'(s - l)} * 28'h000_1000 / {12'h000, 16'(u - l)};
		return (q > {16'h0000, CODE_FULL}) ? CODE_FULL : q[11:0];
	endfunction
endpackage

// ### common/afsc_link_if.sv
// Serial link between the host controller and the converter
`timescale 1ns/1ps
`default_nettype none
interface afsc_link_if;
	logic cs_n;
	logic sclk;
	logic serial_in;
	logic frame_sync_input;
	logic conversion_start_input;
	logic hardware_sleep_input;
	logic serial_out;
	logic serial_out_oe;
	logic int_eoc_n;

	modport dev (
		input cs_n, sclk, serial_in, frame_sync_input, conversion_start_input, hardware_sleep_input,
		output serial_out, serial_out_oe, int_eoc_n
	);
	modport host (
		output cs_n, sclk, serial_in, frame_sync_input, conversion_start_input, hardware_sleep_input,
		input serial_out, serial_out_oe, int_eoc_n
	);
endinterface
`default_nettype wire

// ### verilog/afsc_device.sv
// Converter end: frame decode, mode sequencing, result queue, power control
//
// Operation
// - Repeat mode: configure, then select channel.
// - Host reads queue and reselects, or reconfigures.
// - Configuration write empties queue; new mode follows.
// - Sweep mode: host reconfigures before each sweep.
// - Repeat sweep runs endlessly after one configuration.
// - Eight-entry queue, interrupt at programmed threshold.
// - Queue fills from fixed channel or sweep.
// - Half threshold interrupts at four results.
// - Conversion: fourteen conversion clocks plus four serial.
// - Host keeps conversion clock at or below ten megahertz.
// - Idle converter powers down, reference stays on.
// - Codes saturate at full scale and zero.
// - Word 8000h puts device to sleep.
// - Hardware sleep input latched asynchronously; powers down at next clock.
// - Twenty milliseconds to resume after sleep.
// - Sleep keeps configuration, empties queue, restarts sweep.
// - Host writes A000h first, then configuration.
// - First conversion after power-up or wake dropped.
// - After interrupt, oldest entry kept until queue read.
// - Queue modes always signal interrupt, not end-of-conversion.
`timescale 1ns/1ps
`default_nettype none
module afsc_device
	import afsc_pkg::*;
#(
	parameter int WAKE = afsc_pkg::WAKE_CYCLES,
	parameter int DEPTH = afsc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Serial link
	afsc_link_if.dev link,
	// Analog side
	input wire logic [15:0] analog_sample,
	input wire logic [15:0] upper_reference_input,
	input wire logic [15:0] lower_reference_input,
	output logic [2:0] channel_select,
	// Power state
	output logic converter_powered,
	output logic reference_powered,
	output logic device_ready
);
	import afsc_pkg::*;

	localparam int WW = $clog2(WAKE + 1);
	localparam int PW = $clog2(DEPTH);

	typedef enum {CV_IDLE, CV_OVERHEAD, CV_RUN} afsc_conv_t;

	logic sclk_q, cs_q, conversion_start_input_q;
	logic rise, fall, frame_start, frame_end, conversion_start_input_rise;
	logic [4:0] bit_cnt;
	logic [15:0] in_sr, out_sr;
	logic [11:0] configuration_register, last_result, result;
	afsc_mode_t mode;
	logic fifo_mode, pin_int, ext, div2;
	logic [3:0] thr;
	logic word_done, is_cfg, is_sleep, is_pop, is_sel, arm_now;
	logic hw_asleep, sw_asleep, asleep;
	logic [WW-1:0] wake_cnt;
	afsc_conv_t state;
	logic [3:0] conv_cnt;
	logic [2:0] ovh_cnt;
	logic half, cclk, start, done, armed, discard;
	logic [2:0] chan, idx;
	logic [11:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr;
	logic [3:0] count;
	logic push, pop, reached;

	// Edges of the serial clock, select and start inputs
	assign rise = link.sclk & ~sclk_q;
	assign fall = ~link.sclk & sclk_q;
	assign frame_start = ~link.cs_n & cs_q;
	assign frame_end = link.cs_n & ~cs_q;
	assign conversion_start_input_rise = link.conversion_start_input & ~conversion_start_input_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			conversion_start_input_q <= 1'b0;
		end else begin
			sclk_q <= link.sclk;
			cs_q <= link.cs_n;
			conversion_start_input_q <= link.conversion_start_input;
		end
	end

	// Decoded configuration fields
	assign mode = afsc_mode_t'(configuration_register[CFG_MODE_LO +: 2]);
	assign fifo_mode = (mode != MODE_ONE_SHOT);
	assign pin_int = configuration_register[CFG_PIN_INT];
	assign ext = configuration_register[CFG_EXT];
	assign div2 = configuration_register[CFG_DIV2];
	assign thr = thr_count(configuration_register[CFG_THR_LO +: 2]);

	// Command bits are taken on rising serial clock, MSB first
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bit_cnt <= 5'h00;
			in_sr <= 16'h0000;
		end else if (frame_start || link.frame_sync_input) begin
			bit_cnt <= 5'h00;
		end else if (rise && !link.cs_n && bit_cnt != FRAME_BITS) begin
			bit_cnt <= 5'(bit_cnt + 5'h01);
			in_sr <= {in_sr[14:0], link.serial_in};
		end
	end

	// Whole-word commands act when the frame closes
	assign word_done = frame_end && (bit_cnt == FRAME_BITS);
	assign is_cfg = word_done && (in_sr[15:12] == CMD_WR_CFG);
	assign is_sleep = word_done && (in_sr == SLEEP_WORD);
	assign is_pop = word_done && (in_sr[15:12] == CMD_RD_FIFO);
	assign is_sel = word_done && !in_sr[15];
	assign arm_now = is_sel && (mode == MODE_ONE_SHOT || mode == MODE_REPEAT);

	// Configuration register; sleep never touches it
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			configuration_register <= CFG_RESET;
		else if (is_cfg)
			configuration_register <= in_sr[11:0];
	end

	// Hardware sleep takes effect without waiting for a clock edge
	always_ff @(posedge clock or posedge rst or posedge link.hardware_sleep_input) begin
		if (rst)
			hw_asleep <= 1'b0;
		else if (link.hardware_sleep_input)
			hw_asleep <= 1'b1;
		else
			hw_asleep <= 1'b0;
	end

	// Software sleep ends at the next access
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			sw_asleep <= 1'b0;
		else if (is_sleep)
			sw_asleep <= 1'b1;
		else if (frame_start)
			sw_asleep <= 1'b0;
	end

	assign asleep = hw_asleep | sw_asleep;

	// Resume delay after either sleep
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			wake_cnt <= '0;
		else if (asleep)
			wake_cnt <= WW'(WAKE);
		else if (wake_cnt != '0)
			wake_cnt <= wake_cnt - 1'b1;
	end

	// Power outputs; the converter idles when it is not selected, not started and not converting
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			converter_powered <= 1'b0;
			reference_powered <= 1'b0;
			device_ready <= 1'b0;
		end else begin
			converter_powered <= ~asleep & (~link.cs_n | link.conversion_start_input | state != CV_IDLE);
			reference_powered <= ~asleep;
			device_ready <= ~asleep & (wake_cnt == '0);
		end
	end

	// Conversion start: frame end for normal sampling, start input for extended
	assign start = (state == CV_IDLE) && !asleep &&
		((is_sel && !ext && (arm_now || armed)) || (conversion_start_input_rise && ext && link.cs_n && armed));

	// Conversion clock enable: every rise, or every other rise when halved
	assign cclk = rise && (!div2 || half);

	// Overhead clocks, then conversion clocks
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= CV_IDLE;
			ovh_cnt <= 3'h0;
			conv_cnt <= 4'h0;
			half <= 1'b0;
		end else if (start) begin
			state <= CV_OVERHEAD;
			ovh_cnt <= OVERHEAD_SCLKS;
			half <= 1'b0;
		end else unique case (state)
			CV_IDLE: begin
			end
			CV_OVERHEAD: begin
				if (rise)
					ovh_cnt <= ovh_cnt - 3'h1;
				if (rise && ovh_cnt == 3'h1) begin
					state <= CV_RUN;
					conv_cnt <= CONV_CLOCKS;
				end
			end
			CV_RUN: begin
				if (rise)
					half <= ~half;
				if (cclk)
					conv_cnt <= conv_cnt - 4'h1;
				if (cclk && conv_cnt == 4'h1)
					state <= CV_IDLE;
			end
		endcase
	end

	assign done = (state == CV_RUN) && cclk && (conv_cnt == 4'h1);
	assign result = sat_code(analog_sample, upper_reference_input, lower_reference_input);

	// Channel of the next conversion, fixed or from the sweep
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			chan <= 3'h0;
			channel_select <= 3'h0;
		end else begin
			if (is_sel)
				chan <= in_sr[14:12];
			if (start)
				channel_select <= (mode[1]) ? sweep_ch(configuration_register[CFG_SEQ_LO +: 2], idx) : (is_sel ? in_sr[14:12] : chan);
		end
	end

	// Sweep position restarts on configuration or sleep
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			idx <= 3'h0;
		else if (asleep || is_cfg)
			idx <= 3'h0;
		else if (start && mode[1])
			idx <= 3'(idx + 3'h1);
	end

	// Permission to convert: cleared at threshold except in repeat sweep
	// Repeat sweep stays armed through sleep so it restarts without a new configuration
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			armed <= 1'b0;
		else if (asleep && mode != MODE_REPEAT_SWEEP)
			armed <= 1'b0;
		else if (is_cfg)
			armed <= in_sr[CFG_MODE_LO + 1];
		else if (arm_now)
			armed <= 1'b1;
		else if ((start && mode == MODE_ONE_SHOT) || (reached && mode != MODE_REPEAT_SWEEP))
			armed <= 1'b0;
	end

	// First result after power-up or wake is thrown away
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			discard <= 1'b1;
		else if (asleep)
			discard <= 1'b1;
		else if (done)
			discard <= 1'b0;
	end

	// Result queue
	assign push = done && fifo_mode && !discard && (count != 4'(DEPTH));
	assign pop = is_pop && (count != 4'h0);
	assign reached = push && (4'(count + 4'h1) == thr);

	always_ff @(posedge clock) begin
		if (push)
			mem[wr_ptr] <= result;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= 4'h0;
		end else if (asleep || is_cfg) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= 4'h0;
		end else begin
			if (push)
				wr_ptr <= PW'(wr_ptr + 1'b1);
			if (pop)
				rd_ptr <= PW'(rd_ptr + 1'b1);
			count <= 4'(count + {3'h0, push} - {3'h0, pop});
		end
	end

	// One-shot result holder
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			last_result <= CODE_ZERO;
		else if (done && !fifo_mode && !discard)
			last_result <= result;
	end

	// Interrupt or end-of-conversion pin; a set in the same cycle wins
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			link.int_eoc_n <= 1'b1;
		end else if (fifo_mode || pin_int) begin
			if (frame_start)
				link.int_eoc_n <= 1'b1;
			if (reached || (done && !fifo_mode))
				link.int_eoc_n <= 1'b0;
		end else begin
			if (start)
				link.int_eoc_n <= 1'b0;
			if (done)
				link.int_eoc_n <= 1'b1;
		end
	end

	// Output word: queue head or one-shot result from the frame start, or configuration after the command
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			out_sr <= 16'h0000;
		else if (frame_start)
			out_sr <= {(fifo_mode && count != 4'h0) ? mem[rd_ptr] : last_result, 4'h0};
		else if (rise && !link.cs_n && bit_cnt == CMD_BITS - 5'h01 && {in_sr[2:0], link.serial_in} == CMD_RD_CFG)
			out_sr <= {1'b0, configuration_register, 3'h0};
		else if (fall && !link.cs_n)
			out_sr <= {out_sr[14:0], 1'b0};
	end

	assign link.serial_out = out_sr[15];

	// Output driven only while selected
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			link.serial_out_oe <= 1'b0;
		else
			link.serial_out_oe <= ~link.cs_n;
	end
endmodule
`default_nettype wire

// ### verilog/afsc_host.sv
// Host end: serial frame engine with a small register port for software
`timescale 1ns/1ps
`default_nettype none
module afsc_host
	import afsc_pkg::*;
#(
	parameter int WAKE = afsc_pkg::WAKE_CYCLES,
	parameter int HALF = afsc_pkg::SCLK_HALF
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Serial link
	afsc_link_if.host link
);
	import afsc_pkg::*;

	localparam int WW = $clog2(WAKE + 1);
	localparam int HW = $clog2(HALF + 1);

	typedef enum {H_IDLE, H_FRAME} afsc_hstate_t;

	afsc_hstate_t state;
	logic [HW-1:0] half_cnt;
	logic sclk_r, edge_now, going_high, going_low;
	logic pending, init_done, sleep_sent;
	logic [15:0] tx_sr, rx_sr, rx_word;
	logic [4:0] rcnt;
	logic [1:0] ctrl;
	logic [WW-1:0] wake_cnt;
	logic int_seen;

	// Free-running serial clock, sized to keep conversion clock legal
	assign edge_now = (half_cnt == HW'(HALF - 1));
	assign going_high = edge_now & ~sclk_r;
	assign going_low = edge_now & sclk_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			half_cnt <= '0;
			sclk_r <= 1'b0;
		end else if (edge_now) begin
			half_cnt <= '0;
			sclk_r <= ~sclk_r;
		end else begin
			half_cnt <= HW'(half_cnt + 1'b1);
		end
	end

	assign link.sclk = sclk_r;

	// Frame engine; the init word A000h goes out first after reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= H_IDLE;
			pending <= 1'b1;
			tx_sr <= INIT_WORD;
			rx_sr <= 16'h0000;
			rx_word <= 16'h0000;
			rcnt <= 5'h00;
			init_done <= 1'b0;
			link.cs_n <= 1'b1;
			link.serial_in <= 1'b0;
			link.frame_sync_input <= 1'b0;
		end else begin
			link.frame_sync_input <= 1'b0;
			unique case (state)
				H_IDLE: begin
					if (reg_write && reg_addr == REG_CMD && !pending) begin
						pending <= 1'b1;
						tx_sr <= reg_wdata;
					end else if (pending && going_low) begin
						state <= H_FRAME;
						link.cs_n <= 1'b0;
						link.frame_sync_input <= 1'b1;
						link.serial_in <= tx_sr[15];
						tx_sr <= {tx_sr[14:0], 1'b0};
						rcnt <= 5'h00;
					end
				end
				H_FRAME: begin
					if (going_high) begin
						rx_sr <= {rx_sr[14:0], link.serial_out};
						rcnt <= 5'(rcnt + 5'h01);
					end else if (going_low && rcnt == FRAME_BITS) begin
						state <= H_IDLE;
						link.cs_n <= 1'b1;
						pending <= 1'b0;
						init_done <= 1'b1;
						rx_word <= rx_sr;
					end else if (going_low) begin
						link.serial_in <= tx_sr[15];
						tx_sr <= {tx_sr[14:0], 1'b0};
					end
				end
			endcase
		end
	end

	// Remembers a sleep word so the next frame starts the resume wait
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			sleep_sent <= 1'b0;
		else if (state == H_IDLE && pending && going_low)
			sleep_sent <= (tx_sr == SLEEP_WORD);
	end

	// Resume wait after software or hardware sleep
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			wake_cnt <= '0;
		else if ((ctrl[CTRL_SLEEP] && reg_write && reg_addr == REG_CTRL && !reg_wdata[CTRL_SLEEP]) ||
			(sleep_sent && state == H_IDLE && pending && going_low))
			wake_cnt <= WW'(WAKE);
		else if (wake_cnt != '0)
			wake_cnt <= wake_cnt - 1'b1;
	end

	// Start and sleep pins straight from the control register
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			ctrl <= 2'h0;
		else if (reg_write && reg_addr == REG_CTRL)
			ctrl <= reg_wdata[1:0];
	end

	assign link.conversion_start_input = ctrl[CTRL_START];
	assign link.hardware_sleep_input = ctrl[CTRL_SLEEP];

	// Interrupt level seen by software
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			int_seen <= 1'b0;
		else
			int_seen <= ~link.int_eoc_n;
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			reg_rdata <= 16'h0000;
		else if (reg_read)
			unique case (reg_addr)
				REG_STATUS: reg_rdata <= {12'h000, wake_cnt != '0, init_done, int_seen, pending};
				REG_RESULT: reg_rdata <= rx_word;
				REG_CTRL: reg_rdata <= {14'h0000, ctrl};
				default: reg_rdata <= 16'h0000;
			endcase
		else
			reg_rdata <= 16'h0000;
	end
endmodule
`default_nettype wire

// ### tb/afsc_sva.sv
// Assertions on the serial link between host and converter
`timescale 1ns/1ps
`default_nettype none
module afsc_sva
	import afsc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Link signals
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic frame_sync_input,
	input wire logic conversion_start_input,
	input wire logic hardware_sleep_input,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic int_eoc_n
);
	logic sclk_q;
	logic cs_q;
	logic first;
	logic [4:0] bits;
	logic [15:0] rx;
	logic sclk_rise;
	logic cs_rise;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Edge detection on serial clock and frame select
	assign sclk_rise = sclk & ~sclk_q;
	assign cs_rise = cs_n & ~cs_q;
	// Edge history and first frame flag
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			first <= 1'b1;
		end else begin
			sclk_q <= sclk;
			cs_q <= cs_n;
			if (cs_rise)
				first <= 1'b0;
		end
	end
	// Bits shifted in while a frame is open
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bits <= 5'h00;
			rx <= 16'h0000;
		end else if (cs_n) begin
			bits <= 5'h00;
		end else if (sclk_rise) begin
			bits <= bits + 5'h01;
			rx <= {rx[14:0], serial_in};
		end
	end
	frame_len_a: assert property (cs_rise |-> bits == 5'h10)
		else $error("frame not sixteen bits");
	init_word_a: assert property (cs_rise && first |-> rx == INIT_WORD)
		else $error("first frame not init word");
	fs_start_a: assert property ($fell(cs_n) |-> frame_sync_input ##1 !frame_sync_input)
		else $error("frame sync not one cycle at start");
	fs_inside_a: assert property (frame_sync_input |-> !cs_n)
		else $error("frame sync outside frame");
	oe_track_a: assert property (1'b1 |=> serial_out_oe == !$past(cs_n))
		else $error("output enable not following select");
	din_stable_a: assert property (sclk_rise && !cs_n |-> $stable(serial_in))
		else $error("serial input moved at sample");
	int_release_a: assert property ($fell(cs_n) && !int_eoc_n |-> ##[1:2] int_eoc_n)
		else $error("interrupt kept after frame start");
	int_hold_a: assert property (!int_eoc_n && cs_n && !hardware_sleep_input |=> !int_eoc_n)
		else $error("interrupt dropped without access");
	int_seen_c: cover property ($fell(int_eoc_n));
	read_seen_c: cover property (cs_rise && rx[15:12] == CMD_RD_FIFO);
	start_seen_c: cover property ($rose(conversion_start_input) && cs_n);
	data_seen_c: cover property (serial_out_oe && serial_out);
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Bench joining host and converter ends over the serial link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import afsc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [15:0] reg_rdata;
	logic [15:0] analog_sample = 16'h0000;
	logic [15:0] upper_ref = 16'hF000;
	logic [15:0] lower_ref = 16'h1000;
	logic [2:0] channel_select;
	logic converter_powered;
	logic reference_powered;
	logic device_ready;
	logic [15:0] tv [8];
	logic [31:0] seed = 32'h0000_001B;
	logic [15:0] w;
	logic [15:0] st;
	int fails = 0;
	int tests_run = 0;
	afsc_link_if link();
	afsc_host #(.WAKE(20), .HALF(2)) afsc_host_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .link(link));
	afsc_device #(.WAKE(20), .DEPTH(8)) afsc_device_inst (.clock(clock), .rst(rst), .link(link),
		.analog_sample(analog_sample), .upper_reference_input(upper_ref), .lower_reference_input(lower_ref),
		.channel_select(channel_select), .converter_powered(converter_powered),
		.reference_powered(reference_powered), .device_ready(device_ready));
	afsc_sva afsc_sva_inst (.clock(clock), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
		.serial_in(link.serial_in), .frame_sync_input(link.frame_sync_input),
		.conversion_start_input(link.conversion_start_input), .hardware_sleep_input(link.hardware_sleep_input),
		.serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe), .int_eoc_n(link.int_eoc_n));
	// Clock of 5 ns
	always #2.5 clock = ~clock;
	// Analog level follows the selected channel
	always @(posedge clock) analog_sample <= tv[channel_select];
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Expected output word: clamped code in the top twelve bits
	function automatic logic [15:0] exp_word(input logic [15:0] s);
		logic [27:0] q;
		if (s >= upper_ref)
			return 16'hFFF0;
		if (s <= lower_ref)
			return 16'h0000;
		q = {12'h000, s - lower_ref} * 28'h000_1000 / {12'h000, upper_ref - lower_ref};
		return {q[11:0], 4'h0};
	endfunction
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clock);
	endtask
	task automatic wait_free(output logic [15:0] s);
		int n = 0;
		s = 16'h0001;
		while (s[0] !== 1'b0 && n < 400) begin
			reg_rd(REG_STATUS, s);
			n++;
		end
		if (n >= 400)
			fails++;
	endtask
	task automatic frame(input logic [15:0] cmd, output logic [15:0] r);
		logic [15:0] s;
		reg_wr(REG_CMD, cmd);
		wait_free(s);
		reg_rd(REG_RESULT, r);
	endtask
	task automatic conv(input int n);
		repeat (n) begin
			reg_wr(REG_CTRL, 16'h0001);
			reg_wr(REG_CTRL, 16'h0000);
			repeat (100) @(posedge clock);
		end
	endtask
	task automatic wake();
		int n = 0;
		while (device_ready !== 1'b1 && n < 500) begin
			@(posedge clock);
			n++;
		end
		if (n >= 500)
			fails++;
	endtask
	task automatic test_done();
		$display("Checks run %0d, failed %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		test_done();
	end
	// Main sequence
	initial begin
		for (int i = 0; i < 8; i++) begin
			seed = xorshift(seed);
			tv[i] = seed[15:0];
		end
		tv[0] = 16'hFFFF;
		tv[2] = 16'h0800;
		tv[4] = 16'hF000;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		wait_free(st);
		`CHK(st[2], 1'b1)
		frame(16'hA166, w);
		conv(3);
		frame(16'hA166, w);
		frame(16'h9000, w);
		`CHK(w[11:0], 12'h166)
		conv(3);
		`CHK(link.int_eoc_n, 1'b1)
		reg_wr(REG_CTRL, 16'h0001);
		reg_wr(REG_CTRL, 16'h0000);
		repeat (56) @(posedge clock);
		`CHK(link.int_eoc_n, 1'b1)
		repeat (40) @(posedge clock);
		`CHK(link.int_eoc_n, 1'b0)
		frame(16'h9000, w);
		for (int k = 0; k < 4; k++) begin
			frame(16'hE000, w);
			`CHK(w, exp_word(tv[2 * k]))
		end
		conv(4);
		`CHK(link.int_eoc_n, 1'b0)
		`CHK(channel_select, 3'h6)
		frame(16'hE000, w);
		`CHK(w, exp_word(tv[0]))
		$display("test sweep done");
		reg_wr(REG_CTRL, 16'h0002);
		repeat (5) @(posedge clock);
		`CHK({reference_powered, converter_powered}, 2'b00)
		reg_wr(REG_CTRL, 16'h0000);
		wake();
		frame(16'h9000, w);
		`CHK(w[11:0], 12'h166)
		conv(4);
		`CHK(link.int_eoc_n, 1'b1)
		conv(1);
		`CHK(link.int_eoc_n, 1'b0)
		$display("test hardware sleep done");
		frame(16'hA123, w);
		frame(16'h3000, w);
		conv(2);
		`CHK(link.int_eoc_n, 1'b0)
		repeat (2) begin
			frame(16'hE000, w);
			`CHK(w, exp_word(tv[3]))
		end
		repeat (200) @(posedge clock);
		`CHK({reference_powered, converter_powered}, 2'b10)
		$display("test repeat done");
		frame(SLEEP_WORD, w);
		repeat (5) @(posedge clock);
		`CHK(reference_powered, 1'b0)
		frame(16'h9000, w);
		wake();
		frame(16'h9000, w);
		`CHK(w[11:0], 12'h123)
		$display("test software sleep done");
		// Repeat mode with the halved conversion clock: first result dropped, two more reach the threshold
		frame(16'hA1A3, w);
		frame(16'h3000, w);
		repeat (3) begin
			reg_wr(REG_CTRL, 16'h0001);
			reg_wr(REG_CTRL, 16'h0000);
			repeat (100) @(posedge clock);
			`CHK(link.int_eoc_n, 1'b1)
			repeat (40) @(posedge clock);
		end
		`CHK(link.int_eoc_n, 1'b0)
		$display("test divide done");
		test_done();
	end
endmodule
`default_nettype wire
